// file: timer_map.svh
`ifndef TIMER_MAP_SVH
`define TIMER_MAP_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define CTRL_OFFSET 8'h00
`define IOCTL_OFFSET 8'h04
`define MODE_OFFSET 8'h08
`define PRESC_OFFSET 8'h0c
`define MAIN_OFFSET 8'h10

// ----------------------------------------
// timer_control_reg fields
// ----------------------------------------
`define CTRL_RUN_BIT 0
`define CTRL_STOP_BIT 1
`define CTRL_STATUS_BIT 2
`define CTRL_EDGE_BIT 4
`define CTRL_UNDER_BIT 5

// ----------------------------------------
// timer_io_control_reg fields
// ----------------------------------------
`define IO_LEVEL_BIT 0
`define IO_PSTOP_BIT 1
`define IO_INVEN_BIT 2
`define IO_PINSEL_BIT 3
`define IO_PININ_BIT 7

// ----------------------------------------
// timer_mode_reg fields
// ----------------------------------------
`define MODE_LSB 0
`define SRC_LSB 4

// ----------------------------------------
// reset values and divider counts
// ----------------------------------------
`define STAGE_RESET 8'hff
`define F8_LAST 3'h7
`define SUB_LAST 5'h1f

`endif

// file: timer_pkg.sv
package timer_pkg;

  typedef enum logic [2:0] {
    MODE_TIMER = 3'h0,
    MODE_PULSE = 3'h1,
    MODE_EVENT = 3'h2,
    MODE_WIDTH = 3'h3,
    MODE_PERIOD = 3'h4
  } mode_t;

  typedef enum logic [2:0] {
    SRC_F1 = 3'h0,
    SRC_F2 = 3'h1,
    SRC_F8 = 3'h2,
    SRC_OSC = 3'h3,
    SRC_SUB32 = 3'h4
  } source_t;

  typedef struct packed {
    logic dataPhase;
    logic [7:0] busAddr;
    logic busWrite;
    logic runControl;
    logic countStatus;
    logic edgeFlag;
    logic underflowFlag;
    logic startLevel;
    logic pulseStop;
    logic invEnable;
    logic pinSelect;
    mode_t mode;
    source_t source;
    logic pulseLevel;
    logic [2:0] divCount;
    logic oscMeta;
    logic oscSync;
    logic oscPrev;
    logic subMeta;
    logic subSync;
    logic subPrev;
    logic [4:0] subDiv;
    logic pinAMeta;
    logic pinASync;
    logic pinBMeta;
    logic pinBSync;
    logic irq;
    logic outA;
    logic oeNA;
    logic outB;
    logic oeNB;
    logic outSec;
    logic oeNSec;
  } timer_state_t;

endpackage

// file: reload_stage.sv
`timescale 1ns/10ps

module reload_stage #(
  parameter int WIDTH = 8
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic tick,
  input wire logic running,
  input wire logic writeEn,
  input wire logic forceStop,
  input wire logic [WIDTH-1:0] writeData,
  output logic [WIDTH-1:0] count,
  output logic underflow
);

  typedef struct packed {
    logic [WIDTH-1:0] reload;
    logic [WIDTH-1:0] count;
    logic pending;
  } stage_t;

  stage_t st;
  stage_t next_st;

  assign count = st.count;
  assign underflow = tick && (st.count == '0);

  // ----------------------------------------
  // reload and count
  // ----------------------------------------
  always_comb begin
    next_st = st;
    if (tick) begin
      if (st.pending || st.count == '0) begin
        next_st.count = st.reload;
        next_st.pending = 1'b0;
      end else begin
        next_st.count = st.count - WIDTH'(1);
      end
    end
    if (writeEn) begin
      next_st.reload = writeData;
      if (running) begin
        next_st.pending = 1'b1;
      end else begin
        next_st.count = writeData;
        next_st.pending = 1'b0;
      end
    end
    if (forceStop) begin
      next_st.reload = {WIDTH{1'b1}};
      next_st.count = {WIDTH{1'b1}};
      next_st.pending = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st <= '0;
      st.reload <= {WIDTH{1'b1}};
      st.count <= {WIDTH{1'b1}};
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  a_stage_decrement: assert property (
    tick && !st.pending && st.count != '0 && !writeEn && !forceStop
    |=> st.count == $past(st.count) - WIDTH'(1))
    else $error("stage did not decrement");
  a_stage_reload: assert property (
    underflow && !writeEn && !forceStop |=> st.count == $past(st.reload))
    else $error("stage did not reload on underflow");
  a_stopped_write: assert property (
    writeEn && !running && !forceStop |=> st.count == $past(writeData))
    else $error("stopped write missed counter");
  a_running_write: assert property (
    writeEn && running && !forceStop |=> st.pending && st.reload == $past(writeData))
    else $error("running write not deferred");
  a_stage_force: assert property (
    forceStop |=> st.count == {WIDTH{1'b1}} && st.reload == {WIDTH{1'b1}})
    else $error("forced stop did not load all ones");

endmodule

// file: prescaled_reload_timer.sv
`timescale 1ns/10ps
`include "timer_map.svh"

module prescaled_reload_timer
  import timer_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic onchipOscClock,
  input wire logic subClock,
  input wire logic primaryTimerPinAIn,
  output logic primaryTimerPinAOut,
  output logic primaryTimerPinAOeN,
  input wire logic primaryTimerPinBIn,
  output logic primaryTimerPinBOut,
  output logic primaryTimerPinBOeN,
  output logic secondaryOutputPinOut,
  output logic secondaryOutputPinOeN,
  output logic timerIrq
);

  timer_state_t st;
  timer_state_t next_st;

  logic addrPhase;
  logic busWriteNow;
  logic ctrlWrite;
  logic ioWrite;
  logic modeWrite;
  logic prescWrite;
  logic mainWrite;
  logic forceStop;
  logic pulseMode;
  logic countMode;
  logic oscRise;
  logic subRise;
  logic srcTick;
  logic countTick;
  logic prescUnder;
  logic mainUnder;
  logic driveOn;
  logic [7:0] prescCount;
  logic [7:0] mainCount;
  logic [31:0] readMux;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  assign addrPhase = hsel && htrans[1] && hready;
  assign busWriteNow = st.dataPhase && st.busWrite;
  assign ctrlWrite = busWriteNow && (st.busAddr == `CTRL_OFFSET);
  assign ioWrite = busWriteNow && (st.busAddr == `IOCTL_OFFSET);
  assign modeWrite = busWriteNow && (st.busAddr == `MODE_OFFSET);
  assign prescWrite = busWriteNow && (st.busAddr == `PRESC_OFFSET);
  assign mainWrite = busWriteNow && (st.busAddr == `MAIN_OFFSET);
  assign forceStop = ctrlWrite && hwdata[`CTRL_STOP_BIT];

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = readMux;

  // ----------------------------------------
  // count source
  // ----------------------------------------
  assign pulseMode = (st.mode == MODE_PULSE);
  assign countMode = (st.mode == MODE_TIMER) || pulseMode;
  assign oscRise = st.oscSync && !st.oscPrev;
  assign subRise = st.subSync && !st.subPrev;

  always_comb begin
    case (st.source)
      SRC_F1: begin
        srcTick = 1'b1;
      end
      SRC_F2: begin
        srcTick = st.divCount[0];
      end
      SRC_F8: begin
        srcTick = (st.divCount == `F8_LAST);
      end
      SRC_OSC: begin
        srcTick = oscRise;
      end
      SRC_SUB32: begin
        srcTick = subRise && (st.subDiv == `SUB_LAST);
      end
      default: begin
        srcTick = 1'b0;
      end
    endcase
  end

  assign countTick = srcTick && st.runControl && countMode;

  // ----------------------------------------
  // prescaler and main timer
  // ----------------------------------------
  reload_stage #(
    .WIDTH(8)
  ) prescStage (
    .clk_sys(clk_sys),
    .reset(reset),
    .tick(countTick),
    .running(st.runControl),
    .writeEn(prescWrite),
    .forceStop(forceStop),
    .writeData(hwdata[7:0]),
    .count(prescCount),
    .underflow(prescUnder)
  );

  reload_stage #(
    .WIDTH(8)
  ) mainStage (
    .clk_sys(clk_sys),
    .reset(reset),
    .tick(prescUnder),
    .running(st.runControl),
    .writeEn(mainWrite),
    .forceStop(forceStop),
    .writeData(hwdata[7:0]),
    .count(mainCount),
    .underflow(mainUnder)
  );

  // ----------------------------------------
  // register read
  // ----------------------------------------
  always_comb begin
    readMux = '0;
    case (st.busAddr)
      `CTRL_OFFSET: begin
        readMux[`CTRL_RUN_BIT] = st.runControl;
        readMux[`CTRL_STATUS_BIT] = st.countStatus;
        readMux[`CTRL_EDGE_BIT] = st.edgeFlag;
        readMux[`CTRL_UNDER_BIT] = st.underflowFlag;
      end
      `IOCTL_OFFSET: begin
        readMux[`IO_LEVEL_BIT] = st.startLevel;
        readMux[`IO_PSTOP_BIT] = st.pulseStop;
        readMux[`IO_INVEN_BIT] = st.invEnable;
        readMux[`IO_PINSEL_BIT] = st.pinSelect;
        readMux[`IO_PININ_BIT] = st.pinSelect ? st.pinBSync : st.pinASync;
      end
      `MODE_OFFSET: begin
        readMux[`MODE_LSB +: 3] = st.mode;
        readMux[`SRC_LSB +: 3] = st.source;
      end
      `PRESC_OFFSET: begin
        readMux[7:0] = prescCount;
      end
      `MAIN_OFFSET: begin
        readMux[7:0] = mainCount;
      end
      default: begin
        readMux = '0;
      end
    endcase
    if (!st.dataPhase || st.busWrite) begin
      readMux = '0;
    end
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_st = st;
    next_st.dataPhase = addrPhase;
    if (addrPhase) begin
      next_st.busAddr = haddr[7:0];
      next_st.busWrite = hwrite;
    end

    next_st.divCount = st.divCount + 3'h1;
    next_st.oscMeta = onchipOscClock;
    next_st.oscSync = st.oscMeta;
    next_st.oscPrev = st.oscSync;
    next_st.subMeta = subClock;
    next_st.subSync = st.subMeta;
    next_st.subPrev = st.subSync;
    if (subRise) begin
      next_st.subDiv = st.subDiv + 5'h01;
    end
    next_st.pinAMeta = primaryTimerPinAIn;
    next_st.pinASync = st.pinAMeta;
    next_st.pinBMeta = primaryTimerPinBIn;
    next_st.pinBSync = st.pinBMeta;

    next_st.countStatus = st.runControl;
    if (ctrlWrite) begin
      next_st.runControl = hwdata[`CTRL_RUN_BIT];
      next_st.edgeFlag = st.edgeFlag & hwdata[`CTRL_EDGE_BIT];
      next_st.underflowFlag = st.underflowFlag & hwdata[`CTRL_UNDER_BIT];
    end
    if (mainUnder) begin
      next_st.underflowFlag = 1'b1;
    end
    if (forceStop) begin
      next_st.runControl = 1'b0;
      next_st.countStatus = 1'b0;
    end

    if (ioWrite) begin
      next_st.startLevel = hwdata[`IO_LEVEL_BIT];
      next_st.pulseStop = hwdata[`IO_PSTOP_BIT];
      next_st.invEnable = hwdata[`IO_INVEN_BIT];
      next_st.pinSelect = hwdata[`IO_PINSEL_BIT];
    end

    if (modeWrite) begin
      next_st.mode = mode_t'(hwdata[`MODE_LSB +: 3]);
      next_st.source = source_t'(hwdata[`SRC_LSB +: 3]);
      next_st.pulseLevel = st.startLevel;
    end else if (mainUnder && pulseMode) begin
      next_st.pulseLevel = !st.pulseLevel;
    end

    next_st.irq = mainUnder;

    driveOn = (next_st.mode == MODE_PULSE) && !next_st.pulseStop;
    next_st.outA = next_st.pulseLevel;
    next_st.outB = next_st.pulseLevel;
    next_st.oeNA = !(driveOn && !next_st.pinSelect);
    next_st.oeNB = !(driveOn && next_st.pinSelect);
    next_st.outSec = !next_st.pulseLevel;
    next_st.oeNSec = !((next_st.mode == MODE_PULSE) && next_st.invEnable);
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st <= '0;
      st.oeNA <= 1'b1;
      st.oeNB <= 1'b1;
      st.oeNSec <= 1'b1;
      st.outSec <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign primaryTimerPinAOut = st.outA;
  assign primaryTimerPinAOeN = st.oeNA;
  assign primaryTimerPinBOut = st.outB;
  assign primaryTimerPinBOeN = st.oeNB;
  assign secondaryOutputPinOut = st.outSec;
  assign secondaryOutputPinOeN = st.oeNSec;
  assign timerIrq = st.irq;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  a_run_start: assert property (
    ctrlWrite && hwdata[`CTRL_RUN_BIT] && !hwdata[`CTRL_STOP_BIT] |=> st.runControl)
    else $error("run bit not set by write");
  a_force_clears_run: assert property (
    forceStop |=> !st.runControl && !st.countStatus ##1 !st.countStatus)
    else $error("forced stop left run or status set");
  a_force_loads_ff: assert property (
    forceStop |=> prescCount == `STAGE_RESET && mainCount == `STAGE_RESET)
    else $error("forced stop did not load ffh");
  a_halt_holds: assert property (
    !st.runControl && !prescWrite && !mainWrite && !forceStop
    |=> $stable(prescCount) && $stable(mainCount))
    else $error("counters moved while halted");
  a_irq_follows: assert property (
    mainUnder |=> timerIrq)
    else $error("underflow gave no interrupt");
  a_irq_cause: assert property (
    timerIrq |-> $past(mainUnder))
    else $error("interrupt without underflow");
  a_flag_set_wins: assert property (
    mainUnder |=> st.underflowFlag)
    else $error("underflow flag lost");
  a_pulse_toggle: assert property (
    mainUnder && pulseMode && !modeWrite |=> st.pulseLevel != $past(st.pulseLevel))
    else $error("pulse level did not toggle");
  a_mode_restart: assert property (
    modeWrite |=> st.pulseLevel == $past(st.startLevel) && primaryTimerPinAOut == st.pulseLevel)
    else $error("start level not restored");
  a_inverse_out: assert property (
    !secondaryOutputPinOeN |-> secondaryOutputPinOut == !primaryTimerPinAOut)
    else $error("secondary pin not inverse");
  a_pulse_stop: assert property (
    ioWrite && hwdata[`IO_PSTOP_BIT] |=> primaryTimerPinAOeN && primaryTimerPinBOeN)
    else $error("primary pin driven while stopped");
  a_pin_route: assert property (
    !primaryTimerPinAOeN |-> !st.pinSelect && primaryTimerPinBOeN)
    else $error("pin routing wrong");
  a_status_follows: assert property (
    !forceStop |=> st.countStatus == $past(st.runControl))
    else $error("count status does not follow run bit");
  a_flag_clear: assert property (
    ctrlWrite && !hwdata[`CTRL_UNDER_BIT] && !mainUnder |=> !st.underflowFlag)
    else $error("underflow flag not cleared by zero");
  a_flag_keep: assert property (
    ctrlWrite && hwdata[`CTRL_UNDER_BIT] && !mainUnder
    |=> st.underflowFlag == $past(st.underflowFlag))
    else $error("underflow flag changed by one");
  a_presc_read: assert property (
    st.dataPhase && !st.busWrite && st.busAddr == `PRESC_OFFSET |-> hrdata[7:0] == prescCount)
    else $error("prescaler read not counter value");

endmodule

// file: pin_partner.sv
`timescale 1ns/10ps
// ----------------------------------------
// far side: oscillator, sub-clock, pulled-up pins
// ----------------------------------------
module pin_partner (
  input wire logic primaryTimerPinAOut,
  input wire logic primaryTimerPinAOeN,
  input wire logic primaryTimerPinBOut,
  input wire logic primaryTimerPinBOeN,
  output logic onchipOscClock,
  output logic subClock,
  output logic primaryTimerPinAIn,
  output logic primaryTimerPinBIn
);
  // free-running on-chip oscillator, 70 ns period
  initial begin
    onchipOscClock = 1'b0;
    #3;
    forever #35 onchipOscClock = ~onchipOscClock;
  end
  // free-running sub-clock, 90 ns period
  initial begin
    subClock = 1'b0;
    #7;
    forever #45 subClock = ~subClock;
  end
  // released pins float up to the pull-up level
  assign primaryTimerPinAIn = primaryTimerPinAOeN ? 1'b1 : primaryTimerPinAOut;
  assign primaryTimerPinBIn = primaryTimerPinBOeN ? 1'b1 : primaryTimerPinBOut;
endmodule

// file: tb_top.sv
`timescale 1ns/10ps
`include "timer_map.svh"

module tb_top
  import timer_pkg::*;
();
  typedef struct {
    string name;
    logic [31:0] val;
  } note_t;
  logic clk_sys, reset, hsel, hwrite, hready, hreadyout, hresp, rdPhase;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic oscClk, subClk, pinAIn, pinAOut, pinAOeN, pinBIn, pinBOut, pinBOeN;
  logic secOut, secOeN, timerIrq, lvl;
  note_t notes[$];
  note_t cur;
  int nErrors, testsRun, g, n, m;
  int divs[3] = '{1, 2, 8};
  int lo[2] = '{3, 143};
  int hi[2] = '{4, 145};

  assign hready = hreadyout;

  prescaled_reload_timer dut_u (.clk_sys(clk_sys), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .onchipOscClock(oscClk),
    .subClock(subClk), .primaryTimerPinAIn(pinAIn), .primaryTimerPinAOut(pinAOut),
    .primaryTimerPinAOeN(pinAOeN), .primaryTimerPinBIn(pinBIn),
    .primaryTimerPinBOut(pinBOut), .primaryTimerPinBOeN(pinBOeN),
    .secondaryOutputPinOut(secOut), .secondaryOutputPinOeN(secOeN), .timerIrq(timerIrq));

  pin_partner partner_u (.primaryTimerPinAOut(pinAOut), .primaryTimerPinAOeN(pinAOeN),
    .primaryTimerPinBOut(pinBOut), .primaryTimerPinBOeN(pinBOeN), .onchipOscClock(oscClk),
    .subClock(subClk), .primaryTimerPinAIn(pinAIn), .primaryTimerPinBIn(pinBIn));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // ----------------------------------------
  // comparison and verdict
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    testsRun++;
    if (got !== exp) begin
      nErrors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic completeRun();
    $display("checks %0d mismatches %0d", testsRun, nErrors);
    if (nErrors == 0 && testsRun > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // read data phase watcher takes the oldest note
  always @(posedge clk_sys) begin
    if (rdPhase) begin
      if (notes.size() == 0) begin
        check("unexpectedRead", 32'h0, 32'h1);
      end else begin
        cur = notes.pop_front();
        check(cur.name, cur.val, hrdata);
        check("hresp", 32'h0, 32'(hresp));
      end
    end
    rdPhase <= hsel && htrans[1] && !hwrite && hready && !reset;
  end

  // ----------------------------------------
  // bus master tasks
  // ----------------------------------------
  task automatic busAddr(input logic [7:0] a, input logic w);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= 3'b010;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    busAddr(a, 1'b1);
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
  endtask

  task automatic rd(input logic [7:0] a, input string name, input logic [31:0] exp);
    notes.push_back('{name, exp});
    busAddr(a, 1'b0);
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
  endtask

  task automatic waitIrq(output int cnt);
    cnt = 0;
    do begin
      @(posedge clk_sys);
      cnt++;
    end while (timerIrq !== 1'b1 && cnt < 3000);
  endtask

  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  initial begin
    #(20 * 20000);
    nErrors++;
    completeRun();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    reset = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    rdPhase = 1'b0;
    nErrors = 0;
    testsRun = 0;
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    void'($urandom(32'h4e5d0b2f));
    rd(`PRESC_OFFSET, "prescReset", 32'hff);
    rd(`MAIN_OFFSET, "mainReset", 32'hff);
    rd(`CTRL_OFFSET, "ctrlReset", 32'h0);
    rd(8'h20, "unmapped", 32'h0);
    wr(`PRESC_OFFSET, 32'h3);
    wr(`MAIN_OFFSET, 32'h2);
    rd(`PRESC_OFFSET, "prescStopped", 32'h3);
    rd(`MAIN_OFFSET, "mainStopped", 32'h2);
    repeat (10) @(posedge clk_sys);
    rd(`PRESC_OFFSET, "prescHeld", 32'h3);
    // underflow period for the divided sources
    for (int s = 0; s < 3; s++) begin
      n = $urandom % 4;
      m = $urandom % 4;
      wr(`MODE_OFFSET, 32'(s) << `SRC_LSB);
      wr(`PRESC_OFFSET, 32'(n));
      wr(`MAIN_OFFSET, 32'(m));
      wr(`CTRL_OFFSET, 32'h1);
      waitIrq(g);
      waitIrq(g);
      check("irqGap", 32'(divs[s] * (n + 1) * (m + 1)), 32'(g));
      wr(`CTRL_OFFSET, 32'h20);
      rd(`CTRL_OFFSET, "flagKept", 32'h20);
      wr(`CTRL_OFFSET, 32'h0);
      rd(`CTRL_OFFSET, "flagCleared", 32'h0);
    end
    // oscillator and sub-clock sources
    for (int s = 0; s < 2; s++) begin
      wr(`MODE_OFFSET, 32'(s + 3) << `SRC_LSB);
      wr(`PRESC_OFFSET, 32'h0);
      wr(`MAIN_OFFSET, 32'h0);
      wr(`CTRL_OFFSET, 32'h1);
      waitIrq(g);
      waitIrq(g);
      check("srcGap", 32'h1, 32'(g >= lo[s] && g <= hi[s]));
      wr(`CTRL_OFFSET, 32'h0);
    end
    // write while running reaches the counter later
    repeat (2) @(posedge clk_sys);
    wr(`MODE_OFFSET, 32'(SRC_F8) << `SRC_LSB);
    rd(`MODE_OFFSET, "modeRead", 32'h20);
    wr(`PRESC_OFFSET, 32'hff);
    wr(`MAIN_OFFSET, 32'hff);
    wr(`CTRL_OFFSET, 32'h1);
    wr(`MAIN_OFFSET, 32'h5);
    rd(`MAIN_OFFSET, "mainDeferred", 32'hff);
    repeat (2100) @(posedge clk_sys);
    rd(`MAIN_OFFSET, "mainLoaded", 32'h5);
    // forced stop with run still set
    wr(`CTRL_OFFSET, 32'h3);
    rd(`CTRL_OFFSET, "ctrlForced", 32'h0);
    repeat (20) @(posedge clk_sys);
    rd(`PRESC_OFFSET, "prescForced", 32'hff);
    rd(`MAIN_OFFSET, "mainForced", 32'hff);
    // measurement modes do not count here
    wr(`MODE_OFFSET, 32'(MODE_WIDTH));
    wr(`CTRL_OFFSET, 32'h31);
    repeat (20) @(posedge clk_sys);
    rd(`PRESC_OFFSET, "prescNoCount", 32'hff);
    rd(`CTRL_OFFSET, "ctrlMeasure", 32'h5);
    wr(`CTRL_OFFSET, 32'h30);
    // pulse output
    wr(`IOCTL_OFFSET, 32'h5);
    rd(`IOCTL_OFFSET, "ioctlRead", 32'h85);
    wr(`MODE_OFFSET, 32'(MODE_PULSE));
    @(negedge clk_sys);
    check("startLevel", 32'h1, 32'(pinAOut));
    check("pinAEnable", 32'h0, 32'(pinAOeN));
    check("secLevel", 32'h0, 32'(secOut));
    check("secEnable", 32'h0, 32'(secOeN));
    wr(`PRESC_OFFSET, 32'h0);
    wr(`MAIN_OFFSET, 32'h3);
    wr(`CTRL_OFFSET, 32'h1);
    waitIrq(g);
    @(negedge clk_sys);
    lvl = pinAOut;
    waitIrq(g);
    @(negedge clk_sys);
    check("pulseGap", 32'h4, 32'(g));
    check("pinToggle", 32'(!lvl), 32'(pinAOut));
    check("secInverse", 32'(lvl), 32'(secOut));
    wr(`IOCTL_OFFSET, 32'h7);
    @(negedge clk_sys);
    check("pulseStopped", 32'h1, 32'(pinAOeN));
    waitIrq(g);
    waitIrq(g);
    check("stillCounting", 32'h4, 32'(g));
    wr(`IOCTL_OFFSET, 32'hd);
    @(negedge clk_sys);
    check("pinBEnable", 32'h0, 32'(pinBOeN));
    check("pinAReleased", 32'h1, 32'(pinAOeN));
    wr(`CTRL_OFFSET, 32'h0);
    repeat (2) @(posedge clk_sys);
    wr(`MODE_OFFSET, 32'(MODE_PULSE));
    @(negedge clk_sys);
    check("levelRestored", 32'h1, 32'(pinBOut));
    wr(`IOCTL_OFFSET, 32'hc);
    wr(`MODE_OFFSET, 32'(MODE_PULSE));
    @(negedge clk_sys);
    check("levelLow", 32'h0, 32'(pinBOut));
    check("secHigh", 32'h1, 32'(secOut));
    repeat (2) @(posedge clk_sys);
    completeRun();
  end
endmodule
